/* File: lseir_pkg.sv */
package lseir_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_LSU_ROUTE_HI_A      = 8'h00;
  localparam logic [7:0] OFS_LSU_ROUTE_HI_B      = 8'h04;
  localparam logic [7:0] OFS_LSU_ROUTE_HI_C      = 8'h08;
  localparam logic [7:0] OFS_SPECIAL_EVENT_ROUTE = 8'h0C;
  localparam logic [7:0] OFS_PORT_ERROR_ROUTE    = 8'h10;
  localparam logic [7:0] OFS_DECODE_BASE         = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS          = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK            = 8'h44;

  // Field layout
  localparam int FIELD_W        = 4;
  localparam int NUM_DEST       = 8;
  localparam int NUM_LSU_HI     = 24;
  localparam int NUM_SPECIAL    = 3;
  localparam int NUM_PORT       = 4;
  localparam int NUM_COND       = 31;
  localparam int SPECIAL_BITS   = 12;
  localparam int PORT_BITS      = 16;
  localparam int COND_SPECIAL   = 24;
  localparam int COND_PORT      = 27;

  // Reset values
  localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
  localparam logic [7:0]  RST_MASK  = 8'h00;

endpackage : lseir_pkg

/* File: lseir_route.sv */
// Operation
// R01: Register A holds eight 4-bit route fields for conditions 8..15, lowest nibble first, reset 0.
// R02: Register B holds eight 4-bit route fields for conditions 16..23, lowest nibble first, reset 0.
// R03: Register C holds eight 4-bit route fields for conditions 24..31, lowest nibble first, reset 0.
// R04: Special event route bits 11:8 steer the logical layer error capture event.
// R05: Special event route bits 7:4 steer the port-write-in request from any port.
// R06: Special event route bits 3:0 steer the multicast event symbol; bits 31:12 read zero.
// R07: Port error route nibbles steer port 0..3 errors upward from bit 0; bits 31:16 read zero.
// R08: A decode bit shows a condition only when its field selects that destination, OR-ed.
// R09: Field value n below 8 selects destination n; higher values route nowhere.
`timescale 1ns/1ps
`default_nettype none

module lseir_route #(
  parameter int NDEST = 8
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Condition inputs, same clock domain
  input  wire logic [23:0] lsu_cond,
  input  wire logic        mcast_evt,
  input  wire logic        pwrite_in_req,
  input  wire logic        llerr_capture,
  input  wire logic [3:0]  port_err,
  // Routed destinations
  output logic [NDEST-1:0] interrupt_destination,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] lsu_route_hi_a_ff;
  logic [31:0] lsu_route_hi_b_ff;
  logic [31:0] lsu_route_hi_c_ff;
  logic [lseir_pkg::SPECIAL_BITS-1:0] special_event_route_ff;
  logic [lseir_pkg::PORT_BITS-1:0]    port_error_route_ff;
  logic [NDEST-1:0] irq_status_ff;
  logic [NDEST-1:0] irq_mask_ff;
  logic [NDEST-1:0] dest_prev_ff;
  logic [31:0]      decode_ff [NDEST];

  logic [lseir_pkg::NUM_COND-1:0] cond;
  logic [3:0]  cond_field [lseir_pkg::NUM_COND];
  logic [31:0] nxt_decode [NDEST];
  logic [NDEST-1:0] nxt_dest;
  logic [NDEST-1:0] dest_rise;
  logic [NDEST-1:0] nxt_status;
  logic [NDEST-1:0] nxt_mask;
  logic        nxt_irq;
  logic [31:0] nxt_prdata;
  logic        nxt_pslverr;
  logic        nxt_pready;
  logic        wr_acc;
  logic        rd_acc;

  // Write strobes, one per writable register
  logic        wr_route_a;
  logic        wr_route_b;
  logic        wr_route_c;
  logic        wr_special;
  logic        wr_port;
  logic        wr_status;
  logic        wr_mask;

  // Route field decode: destination d selected by field value
  function automatic logic route_hits(input logic [3:0] fld, input int d);
    route_hits = (fld[3] == 1'b0) && (int'(fld[2:0]) == d); // R09
  endfunction : route_hits

  // Field of condition k across all route registers
  function automatic logic [3:0] field_of(input int k, input logic [95:0] load_store_unit,
                                          input logic [11:0] spc, input logic [15:0] prt);
    if (k < lseir_pkg::COND_SPECIAL) begin
      field_of = load_store_unit[k*4 +: 4]; // R01 R02 R03
    end else if (k < lseir_pkg::COND_PORT) begin
      field_of = spc[(k-lseir_pkg::COND_SPECIAL)*4 +: 4]; // R04 R05 R06
    end else begin
      field_of = prt[(k-lseir_pkg::COND_PORT)*4 +: 4]; // R07
    end
  endfunction : field_of

  // Address match shared by the write strobes
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  assign cond   = {port_err, llerr_capture, pwrite_in_req, mcast_evt, lsu_cond};
  assign wr_acc = psel & penable & pwrite & clk_en;
  assign rd_acc = psel & ~penable & ~pwrite & clk_en;

  // A write lands only in the access phase, where pready is already high
  assign wr_route_a = wr_acc & addr_is(paddr, lseir_pkg::OFS_LSU_ROUTE_HI_A);
  assign wr_route_b = wr_acc & addr_is(paddr, lseir_pkg::OFS_LSU_ROUTE_HI_B);
  assign wr_route_c = wr_acc & addr_is(paddr, lseir_pkg::OFS_LSU_ROUTE_HI_C);
  assign wr_special = wr_acc & addr_is(paddr, lseir_pkg::OFS_SPECIAL_EVENT_ROUTE);
  assign wr_port    = wr_acc & addr_is(paddr, lseir_pkg::OFS_PORT_ERROR_ROUTE);
  assign wr_status  = wr_acc & addr_is(paddr, lseir_pkg::OFS_IRQ_STATUS);
  assign wr_mask    = wr_acc & addr_is(paddr, lseir_pkg::OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Route field of every condition, gathered once for all destinations
  always_comb begin
    for (int k = 0; k < lseir_pkg::NUM_COND; k++) begin
      cond_field[k] = field_of(k,
                               {lsu_route_hi_c_ff, lsu_route_hi_b_ff, lsu_route_hi_a_ff},
                               special_event_route_ff, port_error_route_ff);
    end
  end

  // Routing: decode bit k of destination d is condition k when routed there
  for (genvar d = 0; d < NDEST; d++) begin : g_dest
    always_comb begin
      nxt_decode[d] = 32'h0000_0000;
      for (int k = 0; k < lseir_pkg::NUM_COND; k++) begin
        nxt_decode[d][k] = cond[k] & route_hits(cond_field[k], d); // R08
      end
    end

    // Decode word is read back over the bus
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        decode_ff[d] <= 32'h0000_0000;
      end else if (clk_en) begin
        decode_ff[d] <= nxt_decode[d];
      end
    end
  end : g_dest

  always_comb begin
    for (int d = 0; d < NDEST; d++) begin
      nxt_dest[d] = |nxt_decode[d]; // R08
    end
  end

  // Registered so the pins never see decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_destination <= '0;
    end else if (clk_en) begin
      interrupt_destination <= nxt_dest;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Route registers, one per word; reserved upper bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsu_route_hi_a_ff <= lseir_pkg::RST_ROUTE;
    end else if (wr_route_a) begin
      lsu_route_hi_a_ff <= pwdata; // R01
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsu_route_hi_b_ff <= lseir_pkg::RST_ROUTE;
    end else if (wr_route_b) begin
      lsu_route_hi_b_ff <= pwdata; // R02
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsu_route_hi_c_ff <= lseir_pkg::RST_ROUTE;
    end else if (wr_route_c) begin
      lsu_route_hi_c_ff <= pwdata; // R03
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_event_route_ff <= lseir_pkg::RST_ROUTE[lseir_pkg::SPECIAL_BITS-1:0];
    end else if (wr_special) begin
      special_event_route_ff <= pwdata[lseir_pkg::SPECIAL_BITS-1:0]; // R04 R05 R06
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_error_route_ff <= lseir_pkg::RST_ROUTE[lseir_pkg::PORT_BITS-1:0];
    end else if (wr_port) begin
      port_error_route_ff <= pwdata[lseir_pkg::PORT_BITS-1:0]; // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status per destination, set on rising edge; set beats clear
  assign dest_rise = interrupt_destination & ~dest_prev_ff;

  always_comb begin
    nxt_status = irq_status_ff;
    if (wr_status) begin
      nxt_status = irq_status_ff & ~pwdata[NDEST-1:0];
    end
    nxt_status = nxt_status | dest_rise;
  end

  // Edge memory for the sticky set; frozen with everything else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_prev_ff <= '0;
    end else if (clk_en) begin
      dest_prev_ff <= interrupt_destination;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= '0;
    end else if (clk_en) begin
      irq_status_ff <= nxt_status;
    end
  end

  always_comb begin
    nxt_mask = irq_mask_ff;
    if (wr_mask) begin
      nxt_mask = pwdata[NDEST-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= NDEST'(lseir_pkg::RST_MASK);
    end else if (clk_en) begin
      irq_mask_ff <= nxt_mask;
    end
  end

  // Built from next-state values so irq tracks status and mask together,
  // with no extra cycle of lag after a mask write
  assign nxt_irq = |(nxt_status & nxt_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path; data registered in setup, one wait-free access phase
  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (paddr >= lseir_pkg::OFS_DECODE_BASE &&
        paddr < lseir_pkg::OFS_DECODE_BASE + 8'(NDEST*4) && paddr[1:0] == 2'b00) begin
      nxt_prdata = decode_ff[3'(paddr[4:2])];
    end else begin
      unique case (paddr)
        lseir_pkg::OFS_LSU_ROUTE_HI_A:      nxt_prdata = lsu_route_hi_a_ff;
        lseir_pkg::OFS_LSU_ROUTE_HI_B:      nxt_prdata = lsu_route_hi_b_ff;
        lseir_pkg::OFS_LSU_ROUTE_HI_C:      nxt_prdata = lsu_route_hi_c_ff;
        lseir_pkg::OFS_SPECIAL_EVENT_ROUTE: nxt_prdata = {20'h00000, special_event_route_ff}; // R06
        lseir_pkg::OFS_PORT_ERROR_ROUTE:    nxt_prdata = {16'h0000, port_error_route_ff}; // R07
        lseir_pkg::OFS_IRQ_STATUS:          nxt_prdata = 32'(irq_status_ff);
        lseir_pkg::OFS_IRQ_MASK:            nxt_prdata = 32'(irq_mask_ff);
        default:                            nxt_pslverr = 1'b1;
      endcase
    end
  end

  // Zero wait states: pready is registered in setup and marks the access phase.
  // Limitation: a master that stretches its access phase sees pready only once.
  assign nxt_pready = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= nxt_pready;
    end
  end

  // Unmapped or unaligned words answer with an error; writes there are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= nxt_pready & nxt_pslverr;
    end
  end

  // Read data taken in setup and held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      prdata <= nxt_prdata;
    end
  end

endmodule : lseir_route

`default_nettype wire

/* File: lseir_route_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lseir_route_monitor #(
  parameter int NDEST = 8
) (
  // Clock and APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Conditions and destinations
  input wire logic [23:0]      lsu_cond,
  input wire logic             mcast_evt,
  input wire logic             pwrite_in_req,
  input wire logic             llerr_capture,
  input wire logic [3:0]       port_err,
  input wire logic [NDEST-1:0] interrupt_destination
);
  logic [31:0]      sh_ff [5];
  logic [NDEST-1:0] e_a, e_b, e_c, e_l, e_w, e_m, e_p;
  // Shadow of the route words, taken at the accepted write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff <= '{default: 32'h0};
    end else if (psel && penable && pready && pwrite && !pslverr && paddr < 8'h14) begin
      sh_ff[paddr[4:2]] <= pwdata;
    end
  end
  function automatic logic [NDEST-1:0] hit(input logic [31:0] r, input logic [7:0] c);
    hit = '0;
    for (int i = 0; i < 8; i++) begin
      if (c[i] && r[4*i+:4] < NDEST) hit[r[4*i+:4]] = 1'b1;
    end
  endfunction : hit
  assign e_a = hit(sh_ff[0], lsu_cond[7:0]);
  assign e_b = hit(sh_ff[1], lsu_cond[15:8]);
  assign e_c = hit(sh_ff[2], lsu_cond[23:16]);
  assign e_l = hit(sh_ff[3], {5'h0, llerr_capture, 2'h0});
  assign e_w = hit(sh_ff[3], {6'h0, pwrite_in_req, 1'b0});
  assign e_m = hit(sh_ff[3], {7'h0, mcast_evt});
  assign e_p = hit(sh_ff[4], {4'h0, port_err});
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_lsu_a_route: assert property ((interrupt_destination & $past(e_a)) == $past(e_a))
    else $error("lsu 8-15 not routed");
  a_lsu_b_route: assert property ((interrupt_destination & $past(e_b)) == $past(e_b))
    else $error("lsu 16-23 not routed");
  a_lsu_c_route: assert property ((interrupt_destination & $past(e_c)) == $past(e_c))
    else $error("lsu 24-31 not routed");
  a_llerr_route: assert property ((interrupt_destination & $past(e_l)) == $past(e_l))
    else $error("capture event not routed");
  a_pwin_route: assert property ((interrupt_destination & $past(e_w)) == $past(e_w))
    else $error("port-write-in not routed");
  a_mcast_route: assert property ((interrupt_destination & $past(e_m)) == $past(e_m))
    else $error("multicast event not routed");
  a_port_route: assert property ((interrupt_destination & $past(e_p)) == $past(e_p))
    else $error("port error not routed");
  a_route_exact: assert property (interrupt_destination ==
    $past(e_a | e_b | e_c | e_l | e_w | e_m | e_p))
    else $error("destination not the OR of routed conditions");
  c_dest_hit: cover property (|interrupt_destination);
  c_bus_err: cover property (pready && pslverr);
  c_bus_wr: cover property (psel && penable && pwrite && pready);
endmodule : lseir_route_monitor
`default_nettype wire

/* File: lseir_route_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lseir_route_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, dest;
  logic [30:0] cv;
  logic [31:0] pwdata, prdata, sts, e, xv;
  logic [31:0] rt [5];
  logic [31:0] wv [5];
  int          bad_count, n_tests;
  lseir_route u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lsu_cond(cv[23:0]), .mcast_evt(cv[24]),
    .pwrite_in_req(cv[25]), .llerr_capture(cv[26]), .port_err(cv[30:27]),
    .interrupt_destination(dest), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // Read compares d, write sends d; response code checked on both
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk({31'h0, pslverr}, {31'h0, err});
    if (!w) chk(prdata, d);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  function automatic logic [31:0] xd(input int k);
    logic [3:0] f;
    f = k < 24 ? rt[k/8][4*(k%8)+:4] : k < 27 ? rt[3][4*(k-24)+:4] : rt[4][4*(k-27)+:4];
    xd = f < 4'h8 ? 32'h1 << f : 32'h0;
  endfunction : xd
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cv, sts, bad_count, n_tests} = '0;
    rt = '{32'h7654_3210, 32'hFEDC_BA98, 32'h0123_4567, 32'h0000_03A5, 32'h0000_1F26};
    wv = '{32'h7654_3210, 32'hFEDC_BA98, 32'h0123_4567, 32'hFFFF_F3A5, 32'hFFFF_1F26};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) bus(1'b0, 8'(4*i), 32'h0, 1'b0);
    for (int i = 0; i < 5; i++) bus(1'b1, 8'(4*i), wv[i], 1'b0);
    for (int i = 0; i < 5; i++) bus(1'b0, 8'(4*i), rt[i], 1'b0);
    // One condition at a time; each idle gap lets the destination fall
    for (int k = 0; k < 31; k++) begin
      cv <= 31'h1 << k;
      repeat (2) @(posedge pclk);
      chk({24'h0, dest}, xd(k));
      sts |= xd(k);
      cv <= '0;
      @(posedge pclk);
    end
    cv <= '1;
    repeat (2) @(posedge pclk);
    chk({24'h0, dest}, sts);
    for (int d = 0; d < 8; d++) begin
      e = '0;
      for (int k = 0; k < 31; k++) begin
        xv = xd(k);
        e[k] = xv[d];
      end
      bus(1'b0, 8'h20 + 8'(4*d), e, 1'b0);
    end
    cv <= '0;
    bus(1'b0, 8'h40, sts, 1'b0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h44, 32'hFF, 1'b0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h40, 32'hFF, 1'b0);
    bus(1'b0, 8'h40, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h44, 32'hFF, 1'b0);
    bus(1'b1, 8'h80, 32'h1, 1'b1);
    bus(1'b0, 8'h80, 32'h0, 1'b1);
    end_of_test();
  end
endmodule : lseir_route_tb_top
bind lseir_route lseir_route_monitor #(.NDEST(NDEST)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .lsu_cond(lsu_cond), .mcast_evt(mcast_evt),
  .pwrite_in_req(pwrite_in_req), .llerr_capture(llerr_capture), .port_err(port_err),
  .interrupt_destination(interrupt_destination));
`default_nettype wire
